/* rtl/bmpc_top.v */
// Operating mode controller and phase configuration register bank.
// Assumes a serial frame decoder outside presents decoded register
// accesses as one-cycle strobes synchronous to i_clk, and that the
// analog monitors present clean levels synchronous to i_clk.

`include "bmpc_map.vh"

module bmpc_top (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Supply and enable detection
  input wire i_supply_above_pon,
  input wire i_chip_enable,
  // Analog monitors
  input wire i_gate_supply_good,
  input wire i_over_temp,
  input wire i_gate_drv_err,
  input wire i_supply_uv,
  input wire i_supply_ov,
  input wire i_vbat_low,
  input wire i_calib_done,
  // Register access port
  input wire i_wr_stb,
  input wire i_rd_stb,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output wire o_wr_locked,
  // Mode and power control
  output wire [2:0] o_mode,
  output wire o_spi_enable,
  output wire o_gate_supply_on,
  output wire o_rail1_on,
  output wire o_rail2_on,
  output wire o_vbat_monitor_en,
  // Phase generation
  output wire [3:0] o_loop1_phase_gen,
  output wire [3:0] o_loop2_phase_gen,
  output wire [3:0] o_phase_rail_sel,
  output wire [3:0] o_phase_active
);

  // ****************************************************
  // Decode helpers
  // ****************************************************

  // True for registers that configuration locking covers
  function is_cfg_addr;
    input [7:0] addr;
    begin
      is_cfg_addr = (addr == `BMPC_ADDR_ASSIGN) ||
                    (addr == `BMPC_ADDR_LOOP1) ||
                    (addr == `BMPC_ADDR_LOOP2);
    end
  endfunction

  // ****************************************************
  // State
  // ****************************************************

  reg [2:0] mode;
  reg [2:0] next_mode;
  reg [3:0] ctrl;
  reg [3:0] phase_assign;
  reg [3:0] loop1_en;
  reg [3:0] loop2_en;
  reg ever_enabled;

  wire powered;
  wire fault;
  wire cfg_writable;
  wire ctrl_writable;
  wire wr_cfg;
  wire wr_ctrl;
  wire setup_bit;
  wire rail_request;
  reg gate_on;
  wire rails_allowed;

  // Both conditions must hold for the device to leave off mode
  assign powered = i_supply_above_pon & i_chip_enable;

  assign setup_bit = ctrl[`BMPC_CTRL_SETUP];
  assign rail_request = ctrl[`BMPC_CTRL_RAIL1] | ctrl[`BMPC_CTRL_RAIL2];

  // Any of these faults drops an operating converter to silence
  // thermal, driver, supply undervoltage or overvoltage fault
  assign fault = i_over_temp | i_gate_drv_err | i_supply_uv | i_supply_ov;

  // ****************************************************
  // Access gating per mode
  // ****************************************************

  // cleared bit reopens writes
  // Fail-silent keeps config read-only until setup bit is cleared
  assign cfg_writable = (mode == `BMPC_MODE_CONFIG) ||
                        (mode == `BMPC_MODE_CALIB) ||
                        ((mode == `BMPC_MODE_FAIL) && !setup_bit);

  assign ctrl_writable = (mode != `BMPC_MODE_OFF);

  assign wr_cfg = i_wr_stb & is_cfg_addr(i_addr) & cfg_writable;
  assign wr_ctrl = i_wr_stb & (i_addr == `BMPC_ADDR_CTRL) & ctrl_writable;

  // Pulse tells the frame decoder a config write was refused
  assign o_wr_locked = i_wr_stb & is_cfg_addr(i_addr) &
                       ctrl_writable & !cfg_writable;

  // ****************************************************
  // Mode sequencer
  // ****************************************************

  // Next mode; loss of power outranks every other transition
  always @*
  begin
    next_mode = mode;
    case (mode)
      `BMPC_MODE_OFF:
        if (powered)
          next_mode = `BMPC_MODE_CONFIG;
      `BMPC_MODE_CONFIG:
        if (setup_bit)
          next_mode = `BMPC_MODE_OPER;
      `BMPC_MODE_OPER:
      begin
        if (fault)
          next_mode = `BMPC_MODE_FAIL;
        else if (!setup_bit && gate_on && !rail_request)
          next_mode = `BMPC_MODE_CALIB;
        else if (!setup_bit)
          next_mode = `BMPC_MODE_CONFIG;
      end
      `BMPC_MODE_FAIL:
        // only a loss of supply or of enable leaves here
        next_mode = `BMPC_MODE_FAIL;
      `BMPC_MODE_CALIB:
      begin
        if (setup_bit)
          next_mode = `BMPC_MODE_OPER;
        else if (i_calib_done)
          next_mode = `BMPC_MODE_CONFIG;
      end
      default:
        next_mode = `BMPC_MODE_OFF;
    endcase
    if (!powered)
      next_mode = `BMPC_MODE_OFF;
  end

  // Mode register
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      mode <= `BMPC_MODE_OFF;
    else
      mode <= next_mode;
  end

  // ****************************************************
  // Register bank
  // ****************************************************

  // Control and configuration storage; only the low nibble is kept,
  // so reserved bits cost no flops and always read back as zero
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl <= `BMPC_CTRL_RST;
      phase_assign <= `BMPC_PHASE_RST;
      loop1_en <= `BMPC_PHASE_RST;
      loop2_en <= `BMPC_PHASE_RST;
    end
    else if (mode == `BMPC_MODE_OFF)
    begin
      ctrl <= `BMPC_CTRL_RST;
      phase_assign <= `BMPC_PHASE_RST;
      loop1_en <= `BMPC_PHASE_RST;
      loop2_en <= `BMPC_PHASE_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= i_wdata[3:0];
      if (wr_cfg && (i_addr == `BMPC_ADDR_ASSIGN))
        phase_assign <= i_wdata[3:0];
      if (wr_cfg && (i_addr == `BMPC_ADDR_LOOP1))
        loop1_en <= i_wdata[3:0];
      if (wr_cfg && (i_addr == `BMPC_ADDR_LOOP2))
        loop2_en <= i_wdata[3:0];
    end
  end

  // Remembers that a rail was requested in operation since power-up
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ever_enabled <= 1'b0;
    else if (mode == `BMPC_MODE_OFF)
      ever_enabled <= 1'b0;
    else if ((mode == `BMPC_MODE_OPER) && rail_request)
      ever_enabled <= 1'b1;
  end

  // ****************************************************
  // Gate supply and rails
  // ****************************************************

  // Gate supply request per mode
  always @*
  begin
    case (mode)
      `BMPC_MODE_CONFIG:
        gate_on = ever_enabled & ctrl[`BMPC_CTRL_GATE];
      `BMPC_MODE_OPER:
      begin
        gate_on = rail_request | ctrl[`BMPC_CTRL_GATE];
      end
      `BMPC_MODE_CALIB:
        gate_on = ctrl[`BMPC_CTRL_GATE];
      default:
      begin
        gate_on = 1'b0;
      end
    endcase
  end

  // wait for gate good
  // Rails are never driven outside operation, which also keeps
  // calibration and configuration from boosting by accident
  assign rails_allowed = (mode == `BMPC_MODE_OPER) & i_gate_supply_good;

  assign o_gate_supply_on = gate_on;
  assign o_rail1_on = rails_allowed & ctrl[`BMPC_CTRL_RAIL1];
  assign o_rail2_on = rails_allowed & ctrl[`BMPC_CTRL_RAIL2];

  assign o_vbat_monitor_en = o_rail1_on | o_rail2_on;

  assign o_spi_enable = (mode != `BMPC_MODE_OFF);
  assign o_mode = mode;

  // ****************************************************
  // Phase generation
  // ****************************************************

  // each rail makes only its enabled phases
  assign o_loop1_phase_gen = loop1_en & {`BMPC_PHASES{o_rail1_on}};
  assign o_loop2_phase_gen = loop2_en & {`BMPC_PHASES{o_rail2_on}};
  assign o_phase_rail_sel = phase_assign;

  // A physical phase switches when the rail it belongs to is on
  genvar gi;
  generate
    for (gi = 0; gi < `BMPC_PHASES; gi = gi + 1)
    begin : g_phase
      assign o_phase_active[gi] = phase_assign[gi] ? o_rail2_on : o_rail1_on;
    end
  endgenerate

  // ****************************************************
  // Read path
  // ****************************************************

  // Read data is registered; unmapped addresses read zero, reads in off mode leave it unchanged
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= `BMPC_DATA_ZERO;
    else if (i_rd_stb && (mode != `BMPC_MODE_OFF))
    begin
      case (i_addr)
        `BMPC_ADDR_CTRL:
          o_rdata <= {`BMPC_HIGH_ZERO, ctrl};
        `BMPC_ADDR_ASSIGN:
          o_rdata <= {`BMPC_HIGH_ZERO, phase_assign};
        `BMPC_ADDR_LOOP1:
          o_rdata <= {`BMPC_HIGH_ZERO, loop1_en};
        `BMPC_ADDR_LOOP2:
          o_rdata <= {`BMPC_HIGH_ZERO, loop2_en};
        `BMPC_ADDR_STATUS:
        begin
          o_rdata <= `BMPC_DATA_ZERO;
          o_rdata[`BMPC_ST_MODE_HI:`BMPC_ST_MODE_LO] <= mode;
          o_rdata[`BMPC_ST_GATE_GOOD] <= i_gate_supply_good;
          o_rdata[`BMPC_ST_GATE_ON] <= gate_on;
          o_rdata[`BMPC_ST_VBAT_LOW] <= i_vbat_low & o_vbat_monitor_en;
          o_rdata[`BMPC_ST_EVER_ON] <= ever_enabled;
        end
        default:
          o_rdata <= `BMPC_DATA_ZERO;
      endcase
    end
  end

endmodule

/* inc/bmpc_map.vh */
// Register map, field positions, reset values and mode codes of the
// boost mode and phase configuration block.
// Assumes it is included by its bare name from the design files.
`ifndef BMPC_MAP_VH
`define BMPC_MAP_VH

// Register addresses on the internal register port
`define BMPC_ADDR_CTRL 8'h00
`define BMPC_ADDR_ASSIGN 8'h02
`define BMPC_ADDR_LOOP1 8'h0B
`define BMPC_ADDR_LOOP2 8'h0C
`define BMPC_ADDR_STATUS 8'h20

// Control register fields
`define BMPC_CTRL_RAIL1 0
`define BMPC_CTRL_RAIL2 1
`define BMPC_CTRL_SETUP 2
`define BMPC_CTRL_GATE 3

// Status register fields
`define BMPC_ST_MODE_LO 0
`define BMPC_ST_MODE_HI 2
`define BMPC_ST_GATE_GOOD 3
`define BMPC_ST_GATE_ON 4
`define BMPC_ST_VBAT_LOW 5
`define BMPC_ST_EVER_ON 6

// Widths and reset values
`define BMPC_PHASES 4
`define BMPC_CTRL_RST 4'h0
`define BMPC_PHASE_RST 4'h0
`define BMPC_DATA_ZERO 8'h00
`define BMPC_HIGH_ZERO 4'h0

// Operating mode codes
`define BMPC_MODE_OFF 3'h0
`define BMPC_MODE_CONFIG 3'h1
`define BMPC_MODE_OPER 3'h2
`define BMPC_MODE_FAIL 3'h3
`define BMPC_MODE_CALIB 3'h4

`endif

/* testbench/bmpc_gate_model.sv */
// Gate driver supply regulator seen from the mode controller.
// Assumes the enable comes from the block and the clock is i_clk.
// ****
// Regulator
// ****
module bmpc_gate_model #(
  parameter int DLY = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_gate_on,
  output logic o_good
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Good only after settling; drops with the enable, never held over
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst || !i_gate_on)
      cnt <= 0;
    else if (cnt < DLY)
      cnt <= cnt + 1;
  end
  assign o_good = (cnt == DLY);
endmodule

/* testbench/bmpc_top_sva.sv */
// Mode and output checks on the ports of bmpc_top.
// Assumes one clock domain and the async high reset.
// ****
// Checker
// ****
module bmpc_chk (
  input wire i_clk,
  input wire i_rst,
  input wire i_supply_above_pon,
  input wire i_chip_enable,
  input wire i_gate_supply_good,
  input wire i_over_temp,
  input wire i_gate_drv_err,
  input wire i_supply_uv,
  input wire i_supply_ov,
  input wire i_wr_stb,
  input wire [7:0] i_addr,
  input wire o_wr_locked,
  input wire [2:0] o_mode,
  input wire o_spi_enable,
  input wire o_gate_supply_on,
  input wire o_rail1_on,
  input wire o_rail2_on,
  input wire o_vbat_monitor_en,
  input wire [3:0] o_loop1_phase_gen
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Power, fault, config address and rail summaries
  wire pwr = i_supply_above_pon & i_chip_enable;
  wire flt = i_over_temp | i_gate_drv_err | i_supply_uv | i_supply_ov;
  wire cfga = (i_addr == 8'h02) || (i_addr == 8'h0B) || (i_addr == 8'h0C);
  wire rails = o_rail1_on | o_rail2_on;
  off_entry_a: assert property (!pwr |=> o_mode == 3'h0)
    else $error("mode not off after power loss");
  off_quiet_a: assert property (o_mode == 3'h0 |-> !o_spi_enable && !o_gate_supply_on)
    else $error("off mode not quiet");
  off_exit_a: assert property (o_mode == 3'h0 && pwr |=> o_mode == 3'h1)
    else $error("off did not go to config");
  cfg_open_a: assert property (i_wr_stb && o_mode == 3'h1 |-> !o_wr_locked)
    else $error("config write refused");
  rails_oper_a: assert property (rails |-> o_mode == 3'h2)
    else $error("rail on outside operation");
  config_lock_a: assert property (i_wr_stb && o_mode == 3'h2 && cfga |-> o_wr_locked)
    else $error("locked write accepted");
  rail_gate_a: assert property (rails |-> i_gate_supply_good && o_gate_supply_on)
    else $error("rail on before gate good");
  vbat_gate_a: assert property (o_vbat_monitor_en == rails)
    else $error("battery monitor mismatch");
  fault_entry_a: assert property (o_mode == 3'h2 && pwr && flt |=> o_mode == 3'h3)
    else $error("fault did not enter fail-silent");
  fail_hold_a: assert property (o_mode == 3'h3 && pwr |=> o_mode == 3'h3 && o_spi_enable)
    else $error("fail-silent left without enable cycle");
  fail_dark_a: assert property (o_mode == 3'h3 |-> !o_gate_supply_on)
    else $error("gate on in fail-silent");
  phase_gate_a: assert property (o_loop1_phase_gen != 4'h0 |-> o_rail1_on)
    else $error("phase made with rail off");
  cover property (o_mode == 3'h2 && o_rail1_on);
  cover property (o_mode == 3'h3);
  cover property (o_mode == 3'h4);
  cover property (i_wr_stb && o_wr_locked);
  cover property (o_mode == 3'h0 ##1 o_mode == 3'h1);
endmodule
bind bmpc_top bmpc_chk u_chk (.i_clk, .i_rst, .i_supply_above_pon, .i_chip_enable,
  .i_gate_supply_good, .i_over_temp, .i_gate_drv_err, .i_supply_uv, .i_supply_ov,
  .i_wr_stb, .i_addr, .o_wr_locked, .o_mode, .o_spi_enable, .o_gate_supply_on,
  .o_rail1_on, .o_rail2_on, .o_vbat_monitor_en, .o_loop1_phase_gen);

/* testbench/tb_boost_mode_and_phase_config.sv */
// Self-checking bench for bmpc_top with a gate regulator model.
// Assumes register strobes last one cycle and rdata lands a cycle later.
// ****
// Bench
// ****
module tb_boost_mode_and_phase_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_supply_above_pon, i_chip_enable, i_wr_stb, i_rd_stb, good, lk;
  logic vlow, cdone;
  logic [3:0] flt;
  logic [7:0] i_addr, i_wdata, rv;
  wire [7:0] o_rdata;
  wire [2:0] o_mode;
  wire [3:0] g1, g2, act, sel;
  wire lock_w, spi, gate, r1, r2, vb;
  int n_fail, n_compared, seed, i, m_l1, m_l2, m_as;
  bmpc_top u_bmpc_top (.i_clk(i_clk), .i_rst(i_rst), .i_supply_above_pon(i_supply_above_pon),
    .i_chip_enable(i_chip_enable), .i_gate_supply_good(good), .i_over_temp(flt[0]),
    .i_gate_drv_err(flt[1]), .i_supply_uv(flt[2]), .i_supply_ov(flt[3]), .i_vbat_low(vlow),
    .i_calib_done(cdone), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_wr_locked(lock_w), .o_mode(o_mode),
    .o_spi_enable(spi), .o_gate_supply_on(gate), .o_rail1_on(r1), .o_rail2_on(r2),
    .o_vbat_monitor_en(vb), .o_loop1_phase_gen(g1), .o_loop2_phase_gen(g2),
    .o_phase_rail_sel(sel), .o_phase_active(act));
  bmpc_gate_model u_bmpc_gate_model (.i_clk(i_clk), .i_rst(i_rst), .i_gate_on(gate), .o_good(good));
  // Clock at 50 MHz
  always #10 i_clk = ~i_clk;
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Strobe stays up until the taking edge; refusal flag is sampled 1 ns after the strobe goes up
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_stb <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    #1 lk = lock_w;
    @(posedge i_clk);
    i_wr_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd_stb <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd_stb <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    n_fail++;
    summarize();
  end
  initial
  begin
    {i_clk, i_rst, i_supply_above_pon, i_chip_enable, i_wr_stb, i_rd_stb} = 6'h10;
    {flt, i_addr, i_wdata, n_fail, n_compared} = 0;
    {vlow, cdone} = 2'h0;
    seed = 83;
    repeat (16) @(posedge i_clk);
    // Battery low stays asserted; it may only show while a rail is on
    vlow <= 1'b1;
    i_rst <= 1'b0;
    i_supply_above_pon <= 1'b1;
    i_chip_enable <= 1'b1;
    step(2);
    for (i = 0; i < 4; i++)
    begin
      chk("mode_cfg", {5'h00, o_mode}, 8'h01);
      m_l1 = $random(seed) & 15;
      m_l2 = $random(seed) & 15;
      m_as = $random(seed) & 15;
      wr(8'h0B, m_l1[7:0]);
      wr(8'h0C, m_l2[7:0]);
      wr(8'h02, m_as[7:0]);
      rd(8'h0B);
      chk("loop1", rv, m_l1[7:0]);
      rd(8'h0C);
      chk("loop2", rv, m_l2[7:0]);
      rd(8'h02);
      chk("assign", rv, m_as[7:0]);
      chk("rail_sel", {4'h0, sel}, m_as[7:0]);
      rd(8'h55);
      chk("unmapped", rv, 8'h00);
      chk("cfg_dark", {5'h00, gate, r1, r2}, 8'h00);
      // Even passes turn on the first rail, odd passes the second
      wr(8'h00, {6'h01, i[0], ~i[0]});
      step(1);
      chk("oper_gate", {3'h0, o_mode, gate, r1}, 8'h0A);
      wr(8'h0B, ~m_l1[7:0] & 8'h0F);
      chk("lock", {7'h00, lk}, 8'h01);
      rd(8'h0B);
      chk("kept", rv, m_l1[7:0]);
      step(8);
      chk("rail_on", {5'h00, r2, r1, vb}, {5'h00, i[0], ~i[0], 1'b1});
      rd(8'h20);
      chk("status", rv, 8'h7A);
      chk("phases", {g2, g1}, i[0] ? {m_l2[3:0], 4'h0} : {4'h0, m_l1[3:0]});
      chk("active", {4'h0, act}, {4'h0, i[0] ? m_as[3:0] : ~m_as[3:0]});
      @(posedge i_clk);
      flt <= 4'h1 << i;
      step(1);
      chk("fail", {2'h0, o_mode, gate, r1, r2}, 8'h18);
      @(posedge i_clk);
      flt <= 4'h0;
      wr(8'h02, 8'h00);
      chk("fail_lock", {7'h00, lk}, 8'h01);
      wr(8'h00, 8'h00);
      wr(8'h02, 8'h0F);
      rd(8'h02);
      chk("reopen", {o_mode, lk, rv[3:0]}, 8'h6F);
      @(posedge i_clk);
      i_chip_enable <= 1'b0;
      step(1);
      chk("off", {4'h0, o_mode, spi}, 8'h00);
      @(posedge i_clk);
      i_chip_enable <= 1'b1;
      step(1);
      rd(8'h02);
      chk("cleared", rv, 8'h00);
      $display("test %0d done", i);
    end
    wr(8'h00, 8'h0C);
    step(1);
    wr(8'h00, 8'h08);
    step(1);
    chk("calib", {3'h0, o_mode, gate, r1}, 8'h12);
    wr(8'h0C, 8'h03);
    chk("cal_open", {7'h00, lk}, 8'h00);
    @(posedge i_clk);
    cdone <= 1'b1;
    @(posedge i_clk);
    cdone <= 1'b0;
    step(1);
    // No rail was enabled since power-up, so the gate stays dark
    chk("cal_exit", {3'h0, o_mode, gate, r1}, 8'h04);
    wr(8'h00, 8'h0D);
    step(1);
    wr(8'h00, 8'h09);
    step(1);
    rd(8'h20);
    chk("cfg_gate", rv, 8'h59);
    $display("test calibration done");
    summarize();
  end
endmodule
